// >>> logic/pdd_regs.sv
// Notes on behaviour
// - 16-bit data port moves words to memory
// - write-only start address, resets to zero
// - 32-bit power control register gates blocks
// - after wake, stay awake counter periods, resuspend
// - restoring normal operation cancels the resuspend
// - counter ticks on slow idle clock
// - bit 15 limits port 2 to full speed
// - bit 14 limits port 1 to full speed
// - bit 11 connects port 2 pull-downs
// - bits 9 and 8 enable overcurrent detect
// - bit 7 keeps second transceiver awake
// - bit 5 low powers down; dummy read wakes
// - bit 4 puts regulator in suspend
module pdd_regs (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic wake_event_in,
    input wire logic slow_idle_clock_in,
    input wire logic dummy_read_in,
    output logic [15:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    output logic mem_wr_out,
    output logic mem_rd_out,
    input wire logic [15:0] mem_rdata_in,
    output pdd_pkg::pdd_power_ctl_t power_ctl_out,
    output logic suspend_out
);
    // ************************************************************
    // helpers
    // ************************************************************
    // offset compare shared by every register select
    function automatic logic hit_offset(input logic [7:0] addr,
                                        input logic [7:0] offset);
        return addr == offset;
    endfunction : hit_offset

    // rising edge of a synchronised level against its last sample
    function automatic logic rising(input logic level,
                                    input logic last);
        return level & ~last;
    endfunction : rising

    // ************************************************************
    // address decode
    // ************************************************************
    // full 8-bit compare: no offset has an alias
    // one select per mapped offset; unmapped offsets select nothing
    wire logic hit_win =
        hit_offset(addr_in, pdd_pkg::DMA_MEMORY_WINDOW_OFF);
    wire logic hit_first =
        hit_offset(addr_in, pdd_pkg::DMA_FIRST_LOCATION_OFF);
    wire logic hit_ctl =
        hit_offset(addr_in, pdd_pkg::POWER_SAVING_CONTROL_OFF);
    wire logic hit_stat =
        hit_offset(addr_in, pdd_pkg::WAKE_STATUS_OFF);

    // ************************************************************
    // storage
    // ************************************************************
    // bus-side register state
    logic [31:0] ctl_reg; // power_saving_control
    logic [31:0] ctl_next;
    logic [15:0] first_reg; // dma_first_location
    logic [15:0] ptr_reg; // running dma memory pointer
    logic [15:0] ptr_next;
    logic [31:0] rdata_reg; // read data, one cycle late
    logic [31:0] rdata_next;
    logic win_rd_reg; // window read pending, data from memory
    // wake sequencer; the count is in slow idle periods
    pdd_pkg::pdd_wake_state_t state_reg;
    pdd_pkg::pdd_wake_state_t state_next;
    logic [15:0] cnt_reg; // slow idle periods spent awake
    logic [15:0] cnt_next;
    // pins from other domains: two stages; on idle and dummy read a third keeps the last level
    logic idle_s1_reg; // synchroniser stage one
    logic idle_s2_reg; // synchroniser stage two
    logic idle_s3_reg; // previous synchronised level
    // the wake request is a level, two stages are enough
    logic wake_s1_reg; // wake request, stage one
    logic wake_s2_reg; // wake request, stage two
    // the dummy read acts on its edge, so it keeps a third stage
    logic dumrd_s1_reg; // dummy read, stage one
    logic dumrd_s2_reg; // dummy read, stage two
    logic dumrd_s3_reg; // dummy read, last level

    // ************************************************************
    // control register next value
    // ************************************************************
    // reserved bits are forced so a careless write cannot upset them
    // trade-off: a fixed mask spares software a read-modify-write
    // for every update, at the cost of never reaching those bits
    assign ctl_next = (wdata_in & ~pdd_pkg::RESERVED_MASK) |
                      (pdd_pkg::POWER_SAVING_CONTROL_RST &
                       pdd_pkg::RESERVED_MASK);

    // ************************************************************
    // dma pointer
    // ************************************************************
    // limitation: the pointer wraps silently at the top of its range
    wire logic win_access = (wr_in | rd_in) & hit_win;
    // start address load restarts the sequence
    assign ptr_next = (wr_in & hit_first) ? wdata_in[15:0] :
                      win_access ? ptr_reg + 16'h0001 : ptr_reg;

    // each window access is one memory cycle at the pointer
    assign mem_addr_out = ptr_reg;
    assign mem_wr_out = wr_in & hit_win;
    assign mem_rd_out = rd_in & hit_win;

    // ************************************************************
    // read mux
    // ************************************************************
    // write-only start address and unmapped offsets read zero
    assign rdata_next = hit_ctl ? ctl_reg :
                        hit_stat ? {29'h0, suspend_out, state_reg} :
                        32'h0000_0000;

    // outside the answer cycle read data are zero, so a stale word
    // is never mistaken for an answer
    // window reads take the memory word, others the register
    assign rdata_out = win_rd_reg ? {16'h0000, mem_rdata_in} :
                                    rdata_reg;

    // ************************************************************
    // register process
    // ************************************************************
    // every software-written flop but reg_off_reg lives here; the pointer moves on
    // each window access so a burst needs no address writes
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // control word starts at its reset value, pointer at zero
            ctl_reg <= pdd_pkg::POWER_SAVING_CONTROL_RST;
            first_reg <= pdd_pkg::DMA_FIRST_LOCATION_RST;
            ptr_reg <= pdd_pkg::DMA_FIRST_LOCATION_RST;
            rdata_reg <= 32'h0000_0000;
            win_rd_reg <= 1'b0;
            mem_wdata_out <= 16'h0000;
        end else begin
            // strobes last one cycle, so each write lands once
            if (wr_in && hit_ctl) begin
                ctl_reg <= ctl_next;
            end
            if (wr_in && hit_first) begin
                first_reg <= wdata_in[15:0];
            end
            if (wr_in && hit_win) begin
                mem_wdata_out <= wdata_in[15:0];
            end
            ptr_reg <= ptr_next;
            rdata_reg <= rd_in ? rdata_next : 32'h0000_0000;
            win_rd_reg <= rd_in & hit_win;
        end
    end

    // ************************************************************
    // synchronisers for pins from other domains
    // ************************************************************
    // every foreign pin passes two flops before logic reads it; the
    // third idle and dummy stages only remember the last level
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            idle_s1_reg <= 1'b0;
            idle_s2_reg <= 1'b0;
            idle_s3_reg <= 1'b0;
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
            dumrd_s1_reg <= 1'b0;
            dumrd_s2_reg <= 1'b0;
            dumrd_s3_reg <= 1'b0;
        end else begin
            idle_s1_reg <= slow_idle_clock_in;
            idle_s2_reg <= idle_s1_reg;
            idle_s3_reg <= idle_s2_reg;
            wake_s1_reg <= wake_event_in;
            wake_s2_reg <= wake_s1_reg;
            dumrd_s1_reg <= dummy_read_in;
            dumrd_s2_reg <= dumrd_s1_reg;
            dumrd_s3_reg <= dumrd_s2_reg;
        end
    end

    // one pulse per slow idle clock period
    wire logic idle_tick = rising(idle_s2_reg, idle_s3_reg);
    // dummy programmed-I/O read seen as a rising edge
    wire logic dummy_rd_edge = rising(dumrd_s2_reg, dumrd_s3_reg);
    // normal operation means the host core clock is running
    wire logic hc_running = ctl_reg[pdd_pkg::CLK_GATE_BIT];
    wire logic [15:0] clk_off_limit = ctl_reg[31:pdd_pkg::CLK_OFF_LSB];
    // either wake source restarts the awake interval
    wire logic wake_any = wake_s2_reg | dummy_rd_edge;

    // ************************************************************
    // wake sequencer
    // ************************************************************
    // the counter only moves on slow ticks, so its period follows
    // that clock, not the fast one
    always_comb begin
        // hold by default so every path assigns both outputs
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            pdd_pkg::PDD_ASLEEP: begin
                // any wake event starts the awake interval
                if (wake_any) begin
                    state_next = pdd_pkg::PDD_AWAKE;
                    cnt_next = 16'h0000;
                end
            end
            pdd_pkg::PDD_AWAKE: begin
                // priority: normal operation, then a new wake, then a tick
                if (hc_running) begin
                    // software restored normal operation
                    state_next = pdd_pkg::PDD_RUNNING;
                end else if (wake_any) begin
                    cnt_next = 16'h0000; // a fresh wake restarts
                end else if (idle_tick) begin
                    if (cnt_reg >= clk_off_limit) begin
                        state_next = pdd_pkg::PDD_ASLEEP;
                    end else begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
            end
            pdd_pkg::PDD_RUNNING: begin
                // gating the clock off again drops back to suspend
                if (!hc_running) begin
                    state_next = pdd_pkg::PDD_ASLEEP;
                end
            end
            default: begin
                // unused encoding: fall back to the safe state
                state_next = pdd_pkg::PDD_ASLEEP;
            end
        endcase
    end

    // starts asleep: clock gate resets off, so nothing runs yet
    // suspend is taken from the next state so the pin never glitches
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= pdd_pkg::PDD_ASLEEP;
            cnt_reg <= 16'h0000;
            suspend_out <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            suspend_out <= state_next == pdd_pkg::PDD_ASLEEP;
        end
    end

    // ************************************************************
    // power controls driven straight from the register, regulator-on from reg_off_reg
    // ************************************************************
    // regulator-off holds until the dummy read wakes the core; a
    // register bit cannot clear itself with the core unpowered, so
    // the wake is reflected on the pin only, not in ctl_reg
    logic reg_off_reg; // core regulator shut down
    // the wake edge wins over a write in the same cycle
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_off_reg <= 1'b0;
        end else if (dummy_rd_edge) begin
            reg_off_reg <= 1'b0;
        end else if (wr_in && hit_ctl) begin
            reg_off_reg <= ~wdata_in[pdd_pkg::REG_ON_BIT];
        end
    end

    // every level comes straight from a flop, so no control glitches
    // reserved bits drive nothing
    assign power_ctl_out.second_port_speed_limit =
        ctl_reg[pdd_pkg::SECOND_SPEED_BIT];
    assign power_ctl_out.first_port_speed_limit =
        ctl_reg[pdd_pkg::FIRST_SPEED_BIT];
    assign power_ctl_out.second_port_pulldowns =
        ctl_reg[pdd_pkg::PULLDOWN_BIT];
    assign power_ctl_out.second_port_overcurrent_detect =
        ctl_reg[pdd_pkg::SECOND_OC_BIT];
    assign power_ctl_out.first_port_overcurrent_detect =
        ctl_reg[pdd_pkg::FIRST_OC_BIT];
    assign power_ctl_out.second_transceiver_awake =
        ctl_reg[pdd_pkg::XCVR_AWAKE_BIT];
    assign power_ctl_out.core_regulator_on = ~reg_off_reg;
    assign power_ctl_out.core_regulator_suspend =
        ctl_reg[pdd_pkg::REG_SUSP_BIT];
    assign power_ctl_out.second_port_otg_comparators =
        ctl_reg[pdd_pkg::SECOND_OTG_BIT];
    assign power_ctl_out.first_port_otg_comparators =
        ctl_reg[pdd_pkg::FIRST_OTG_BIT];
    assign power_ctl_out.host_core_clock_gate =
        ctl_reg[pdd_pkg::CLK_GATE_BIT];

    // first_reg is stored but no logic reads it back;
    // software never sees it, the port reads zero
    wire logic [15:0] unused_first = first_reg;
endmodule : pdd_regs

// >>> logic/pdd_pkg.sv
package pdd_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] DMA_MEMORY_WINDOW_OFF = 8'h60;
    localparam logic [7:0] DMA_FIRST_LOCATION_OFF = 8'hcc;
    localparam logic [7:0] POWER_SAVING_CONTROL_OFF = 8'hd0;
    // hcd state readback, a register of our own
    localparam logic [7:0] WAKE_STATUS_OFF = 8'hd4;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] DMA_FIRST_LOCATION_RST = 16'h0000;
    localparam logic [31:0] POWER_SAVING_CONTROL_RST = 32'h03e8_1ba0;

    // ************************************************************
    // field positions in power_saving_control
    // ************************************************************
    localparam int CLK_OFF_LSB = 16;
    localparam int SECOND_SPEED_BIT = 15;
    localparam int FIRST_SPEED_BIT = 14;
    localparam int PULLDOWN_BIT = 11;
    localparam int SECOND_OC_BIT = 9;
    localparam int FIRST_OC_BIT = 8;
    localparam int XCVR_AWAKE_BIT = 7;
    localparam int REG_ON_BIT = 5;
    localparam int REG_SUSP_BIT = 4;
    localparam int SECOND_OTG_BIT = 2;
    localparam int FIRST_OTG_BIT = 1;
    localparam int CLK_GATE_BIT = 0;
    // reserved bits 13,12,10,6,3 always take their reset value
    localparam logic [31:0] RESERVED_MASK = 32'h0000_3448;

    // wake sequencer states, gray along the usual path
    typedef enum logic [1:0] {
        PDD_ASLEEP = 2'b00,
        PDD_AWAKE = 2'b01,
        PDD_RUNNING = 2'b11
    } pdd_wake_state_t;

    // outgoing power and port controls
    typedef struct packed {
        logic second_port_speed_limit;
        logic first_port_speed_limit;
        logic second_port_pulldowns;
        logic second_port_overcurrent_detect;
        logic first_port_overcurrent_detect;
        logic second_transceiver_awake;
        logic core_regulator_on;
        logic core_regulator_suspend;
        logic second_port_otg_comparators;
        logic first_port_otg_comparators;
        logic host_core_clock_gate;
    } pdd_power_ctl_t;

    // one internal memory access request
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } pdd_mem_req_t;
endpackage : pdd_pkg

// >>> verif/pdd_mem_model.sv
// ****
// memory stand-in
// ****
module pdd_mem_model (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [15:0] mem_addr_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic mem_wr_out,
    input wire logic mem_rd_out,
    output logic [15:0] mem_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256]; // small, address wraps
    logic [7:0] wa_reg; // address of last cycle
    logic wp_reg; // write data lands one cycle late
    // idle read bus toggles so stale data never matches
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wp_reg <= 1'b0;
            wa_reg <= 8'h00;
            mem_rdata_in <= 16'h5a5a;
        end else begin
            wp_reg <= mem_wr_out;
            wa_reg <= mem_addr_out[7:0];
            if (wp_reg) mem[wa_reg] <= mem_wdata_out;
            if (mem_rd_out) mem_rdata_in <= mem[mem_addr_out[7:0]];
            else mem_rdata_in <= ~mem_rdata_in;
        end
    end
endmodule : pdd_mem_model

// >>> verif/pdd_props.sv
// ****
// port checker
// ****
module pdd_props (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [15:0] mem_addr_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic mem_wr_out,
    input wire logic mem_rd_out,
    input wire logic [15:0] mem_rdata_in,
    input wire pdd_pkg::pdd_power_ctl_t power_ctl_out,
    input wire logic suspend_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    wire logic win = addr_in == pdd_pkg::DMA_MEMORY_WINDOW_OFF; // data port
    wire logic ptr = addr_in == pdd_pkg::DMA_FIRST_LOCATION_OFF; // start
    wire logic ctl = addr_in == pdd_pkg::POWER_SAVING_CONTROL_OFF; // power
    wire logic gate = power_ctl_out.host_core_clock_gate; // normal op
    chk_win_strobes: assert property (mem_wr_out == (wr_in && win)
        && mem_rd_out == (rd_in && win)) else $error("window strobe wrong");
    chk_ptr_load: assert property (wr_in && ptr |=>
        mem_addr_out == $past(wdata_in[15:0])) else $error("pointer load");
    chk_ptr_step: assert property ((wr_in || rd_in) && win |=>
        mem_addr_out == $past(mem_addr_out) + 16'h1) else $error("step");
    chk_wdata_take: assert property (wr_in && win |=>
        mem_wdata_out == $past(wdata_in[15:0])) else $error("wdata");
    chk_win_rdata: assert property (rd_in && win |=>
        rdata_out == {16'h0, mem_rdata_in}) else $error("window read");
    chk_start_zero: assert property (rd_in && ptr |=>
        rdata_out == 32'h0) else $error("start reads nonzero");
    chk_rd_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("rdata without read");
    // one check per group of control fields
    chk_ctl_ports: assert property (
        wr_in && ctl |=> power_ctl_out[10:5] ==
        {$past(wdata_in[15:14]), $past(wdata_in[11]), $past(wdata_in[9:7])})
        else $error("port controls");
    chk_ctl_power: assert property (
        wr_in && ctl |=> power_ctl_out[4:0] ==
        {$past(wdata_in[5:4]), $past(wdata_in[2:0])}) else $error("power");
    chk_run_holds: assert property (
        (gate && !suspend_out) [*2] ##1 gate |-> !suspend_out)
        else $error("resuspend while running");
    chk_gate_sleep: assert property (
        $fell(gate) |-> ##[1:3] suspend_out)
        else $error("no sleep after gate off");
    cover property (rd_in && win);
    cover property (gate && !suspend_out);
    cover property ($fell(suspend_out));
    cover property ($rose(suspend_out));
endmodule : pdd_props

bind pdd_regs pdd_props pdd_props_inst (.clock_in, .resetn_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .mem_addr_out, .mem_wdata_out,
    .mem_wr_out, .mem_rd_out, .mem_rdata_in, .power_ctl_out, .suspend_out);

// >>> verif/tb_top.sv
// ****
// bench
// ****
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0;
    logic wake_event_in = 0, slow_idle_clock_in = 0, dummy_read_in = 0;
    logic [7:0] addr_in = 0;
    logic [31:0] wdata_in = 0, rdata_out, v, d;
    logic [15:0] mem_addr_out, mem_wdata_out, mem_rdata_in, a, q [4];
    logic mem_wr_out, mem_rd_out, suspend_out;
    pdd_pkg::pdd_power_ctl_t power_ctl_out;
    int failures = 0, comparisons = 0;
    integer seed = 32'h95ae912d;
    pdd_regs pdd_regs_inst (.clock_in, .resetn_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .wake_event_in, .slow_idle_clock_in,
        .dummy_read_in, .mem_addr_out, .mem_wdata_out, .mem_wr_out,
        .mem_rd_out, .mem_rdata_in, .power_ctl_out, .suspend_out);
    pdd_mem_model pdd_mem_model_inst (.clock_in, .resetn_in, .mem_addr_out,
        .mem_wdata_out, .mem_wr_out, .mem_rd_out, .mem_rdata_in);
    initial forever #5 clock_in = ~clock_in;
    task end_sim;
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clock_in);
        wr_in <= 1;
        addr_in <= ad;
        wdata_in <= dt;
        @(posedge clock_in);
        wr_in <= 0;
        #1;
    endtask : wr
    task rd(input logic [7:0] ad, output logic [31:0] dt);
        @(posedge clock_in);
        rd_in <= 1;
        addr_in <= ad;
        @(posedge clock_in);
        rd_in <= 0;
        #1 dt = rdata_out;
    endtask : rd
    // slow clock only toggles on request, 16 fast cycles a period
    task ticks(input int n);
        repeat (n) begin
            repeat (8) @(posedge clock_in);
            slow_idle_clock_in <= 1;
            repeat (8) @(posedge clock_in);
            slow_idle_clock_in <= 0;
        end
    endtask : ticks
    task wake;
        @(posedge clock_in) wake_event_in <= 1;
        repeat (4) @(posedge clock_in);
        wake_event_in <= 0;
        for (int i = 0; i < 20 && suspend_out !== 1'b0; i++)
            @(posedge clock_in);
        if (suspend_out !== 1'b0) begin
            failures++;
            end_sim;
        end
    endtask : wake
    function automatic logic [31:0] ectl(input logic [31:0] x);
        return {21'h0, x[15:14], x[11], x[9:7], x[5:4], x[2:0]};
    endfunction : ectl
    // reserved bits always carry their reset value
    function automatic logic [31:0] fix(input logic [31:0] x);
        return (x & ~32'h0000_3448) | 32'h0000_1000;
    endfunction : fix
    initial begin
        repeat (50000) @(posedge clock_in);
        failures++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clock_in);
        resetn_in <= 1;
        rd(8'hd0, d);
        chk(d, 32'h03e8_1ba0);
        chk({21'h0, power_ctl_out}, ectl(32'h03e8_1ba0));
        chk({15'h0, suspend_out, mem_addr_out}, 32'h0001_0000);
        rd(8'hcc, d);
        chk(d, 32'h0);
        rd(8'h44, d);
        chk(d, 32'h0);
        repeat (20) begin
            v = fix($random(seed));
            wr(8'hd0, v);
            chk(32'(power_ctl_out), ectl(v));
            rd(8'hd0, d);
            chk(d, v);
        end
        a = 16'($random(seed));
        wr(8'hcc, {16'h0, a});
        chk(mem_addr_out, {16'h0, a});
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            q[i] = d[15:0];
            wr(8'h60, d);
            chk(mem_addr_out, {16'h0, a + 16'(i + 1)});
        end
        wr(8'hcc, {16'h0, a});
        for (int i = 0; i < 4; i++) begin
            rd(8'h60, d);
            chk(d, {16'h0, q[i]});
        end
        wr(8'hd0, 32'h0002_1ba0);
        wake;
        rd(8'hd4, d);
        chk(d, 32'h1);
        ticks(2);
        repeat (200) @(posedge clock_in);
        chk(suspend_out, 0);
        ticks(1);
        chk(suspend_out, 1);
        rd(8'hd4, d);
        chk(d, 32'h4);
        wake;
        wr(8'hd0, 32'h0002_1ba1);
        ticks(5);
        chk(suspend_out, 0);
        rd(8'hd4, d);
        chk(d, 32'h3);
        wr(8'hd0, 32'h0002_1ba0);
        repeat (3) @(posedge clock_in);
        chk(suspend_out, 1);
        wr(8'hd0, 32'h0002_1b80);
        chk(power_ctl_out.core_regulator_on, 0);
        @(posedge clock_in) dummy_read_in <= 1;
        repeat (6) @(posedge clock_in);
        #1 chk(power_ctl_out.core_regulator_on, 1);
        rd(8'hd0, d);
        chk(d, 32'h0002_1b80);
        end_sim;
    end
endmodule : tb_top
